/* File: src/reset_source_logic.sv */
// reset source logic: pin, address trap and system clock resets
// Summary of operation
// - pin held low three machine cycles (twelve clocks) applies reset
// - on release, execution starts at vector fetched from top two locations
// - fetch from sfr area, or ram when ram trap enabled, raises trap
// - address trap reset lasts at most 24 oscillator periods
// - internal resets drive reset pin low up to 24 periods
// - illegal oscillator disable writes raise a system clock reset
// - oscillator keeps running despite the offending disable write
// - system clock reset completes within 24 periods, pin low same time
// - trap response selectable reset or interrupt; ram area selectable
// - every reset clears all interrupt request latches
// - trap action defaults to reset; clear to zero for interrupt
`timescale 1ns/1ps
module reset_source_logic
	import reset_source_pkg::*;
#(
	parameter int RST_LEN = INT_RST_MAX
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	// reset pin, open drain
	input  wire logic        reset_pin_in,
	output logic             reset_pin_out,
	output logic             reset_pin_oe,
	// core fetch monitor
	input  wire logic        fetch_valid,
	input  wire logic        fetch_in_sfr,
	input  wire logic        fetch_in_ram,
	// interrupt latch set requests from other sources
	input  wire logic [15:0] irq_set,
	// core reset control
	output logic             core_reset,
	output logic [15:0]      start_vector,
	output logic             osc_run,
	output logic             irq,
	// axi4-lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready
);
	typedef enum logic [1:0] {RUN, EXT_RST, INT_RST} rst_state_t;

	rst_state_t        state_ff, nxt_state;
	logic [4:0]        ctrl_ff;
	logic [ST_W-1:0]   status_ff, mask_ff;
	logic [LATCH_W-1:0] latch_ff;
	logic [4:0]        low_cnt_ff;
	logic [4:0]        int_cnt_ff;
	logic              aw_ff, w_ff;
	logic [7:0]        awaddr_ff;
	logic [31:0]       wdata_ff;
	logic              wstrb0_ff;

	// fetch trap decode
	wire trap_hit = fetch_valid && state_ff == RUN &&
		(fetch_in_sfr || (fetch_in_ram && ctrl_ff[CTRL_RAM_TRAP]));
	wire trap_rst = trap_hit && ctrl_ff[CTRL_TRAP_ACT];
	wire trap_irq = trap_hit && !ctrl_ff[CTRL_TRAP_ACT];

	// write path decode
	wire       wr_go    = aw_ff && w_ff && !s_bvalid;
	wire       wr_ctrl  = wr_go && awaddr_ff == OFS_CTRL && wstrb0_ff;
	wire       wr_mask  = wr_go && awaddr_ff == OFS_MASK && wstrb0_ff;
	wire       wr_latch = wr_go && awaddr_ff == OFS_LATCH && wstrb0_ff;
	wire       wr_ok    = awaddr_ff == OFS_CTRL || awaddr_ff == OFS_MASK ||
		awaddr_ff == OFS_LATCH || awaddr_ff == OFS_STATUS;
	wire [4:0] new_ctrl = wdata_ff[4:0];
	wire       old_main = ctrl_ff[CTRL_MAIN_OSC];
	wire       old_sub  = ctrl_ff[CTRL_SUB_OSC];
	wire       new_main = new_ctrl[CTRL_MAIN_OSC];
	wire       new_sub  = new_ctrl[CTRL_SUB_OSC];
	wire       sel      = ctrl_ff[CTRL_CLK_SEL];
	// illegal disable: both cleared, or the one in use cleared
	wire clk_bad = wr_ctrl && (
		(!new_main && !new_sub && (old_main || old_sub)) ||
		(old_main && !new_main && !sel) ||
		(old_sub && !new_sub && sel));

	// pin sampling: count of low samples, whole machine cycles
	wire pin_low  = !reset_pin_in && !reset_pin_oe;
	wire ext_hit  = pin_low && low_cnt_ff >= 5'(EXT_MIN_CYC - 1);
	wire int_done = int_cnt_ff == 5'(RST_LEN - 1);
	wire any_rst  = nxt_state != RUN;

	// read path decode
	wire rd_go = s_arvalid && s_arready;
	wire [31:0] rd_word =
		s_araddr == OFS_CTRL   ? {27'h000_0000, ctrl_ff} :
		s_araddr == OFS_STATUS ? {28'h000_0000, status_ff} :
		s_araddr == OFS_MASK   ? {28'h000_0000, mask_ff} :
		s_araddr == OFS_LATCH  ? {16'h0000, latch_ff} : 32'h0000_0000;
	wire rd_ok = s_araddr == OFS_CTRL || s_araddr == OFS_STATUS ||
		s_araddr == OFS_MASK || s_araddr == OFS_LATCH;
	wire rd_status = rd_go && s_araddr == OFS_STATUS;
	wire [ST_W-1:0] ev = {clk_bad, trap_irq, trap_rst, ext_hit && state_ff == RUN};

	// reset sequencer state decision
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			RUN: begin
				if (ext_hit)
					nxt_state = EXT_RST;
				else if (trap_rst || clk_bad)
					nxt_state = INT_RST;
			end
			EXT_RST: begin
				if (reset_pin_in)
					nxt_state = RUN;
			end
			INT_RST: begin
				if (int_done)
					nxt_state = RUN;
			end
		endcase
	end

	// sequencer and pin counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff   <= EXT_RST;
			low_cnt_ff <= 5'h00;
			int_cnt_ff <= 5'h00;
		end else if (clk_en) begin
			state_ff   <= nxt_state;
			low_cnt_ff <= !pin_low ? 5'h00 : ext_hit ? low_cnt_ff : low_cnt_ff + 5'h01;
			int_cnt_ff <= nxt_state == INT_RST && state_ff == INT_RST ?
				int_cnt_ff + 5'h01 : 5'h00;
		end
	end

	// outputs to core and pin; internal resets pull the pin
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			core_reset    <= 1'b1;
			reset_pin_oe  <= 1'b0;
			reset_pin_out <= 1'b0;
			start_vector  <= VEC_ADDR;
			osc_run       <= 1'b1;
		end else if (clk_en) begin
			core_reset   <= any_rst;
			reset_pin_oe <= nxt_state == INT_RST;
			start_vector <= VEC_ADDR;
			osc_run      <= 1'b1;
		end
	end

	// control register; an illegal write in run reloads CTRL_RESET, outside run it keeps the old oscillator bits
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			ctrl_ff <= CTRL_RESET;
		else if (clk_en) begin
			if (nxt_state != RUN && state_ff == RUN)
				ctrl_ff <= CTRL_RESET;
			else if (wr_ctrl && !clk_bad)
				ctrl_ff <= new_ctrl;
			else if (clk_bad)
				ctrl_ff <= {ctrl_ff[4:2], new_ctrl[1:0]};
		end
	end

	// interrupt request latches, set wins over software clear
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			latch_ff <= 16'h0000;
		else if (clk_en) begin
			if (any_rst)
				latch_ff <= 16'h0000;
			else
				latch_ff <= (wr_latch ? (latch_ff & wdata_ff[15:0]) : latch_ff) |
					irq_set | (16'(trap_irq) << LATCH_TRAP);
		end
	end

	// sticky status, cleared by read, mask, interrupt output
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			status_ff <= 4'h0;
			mask_ff   <= 4'h0;
			irq       <= 1'b0;
		end else if (clk_en) begin
			status_ff <= (rd_status ? 4'h0 : status_ff) | ev;
			if (wr_mask)
				mask_ff <= wdata_ff[ST_W-1:0];
			irq <= |(((rd_status ? 4'h0 : status_ff) | ev) & mask_ff);
		end
	end

	// axi write channels: capture address and data in any order
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_ff     <= 1'b0;
			w_ff      <= 1'b0;
			awaddr_ff <= 8'h00;
			wdata_ff  <= 32'h0000_0000;
			wstrb0_ff <= 1'b0;
			s_awready <= 1'b1;
			s_wready  <= 1'b1;
			s_bvalid  <= 1'b0;
			s_bresp   <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_awvalid && s_awready) begin
				aw_ff     <= 1'b1;
				awaddr_ff <= s_awaddr;
				s_awready <= 1'b0;
			end
			if (s_wvalid && s_wready) begin
				w_ff      <= 1'b1;
				wdata_ff  <= s_wdata;
				wstrb0_ff <= s_wstrb[0];
				s_wready  <= 1'b0;
			end
			if (wr_go) begin
				s_bvalid <= 1'b1;
				s_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
				aw_ff    <= 1'b0;
				w_ff     <= 1'b0;
			end else if (s_bvalid && s_bready) begin
				s_bvalid  <= 1'b0;
				s_awready <= 1'b1;
				s_wready  <= 1'b1;
			end
		end
	end

	// axi read channel: one cycle to answer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= RESP_OKAY;
		end else if (clk_en) begin
			if (rd_go) begin
				s_arready <= 1'b0;
				s_rvalid  <= 1'b1;
				s_rdata   <= rd_word;
				s_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_rvalid && s_rready) begin
				s_rvalid  <= 1'b0;
				s_arready <= 1'b1;
			end
		end
	end

	// checks, one per guarded behaviour; the tag on each label line names the rule
	sequence s_trap_reset;
		trap_rst && clk_en;
	endsequence
	sequence s_clk_bad;
		clk_bad && clk_en;
	endsequence
	sequence s_ext_hit;
		ext_hit && state_ff == RUN && clk_en;
	endsequence
	// pin drive starts, then must end within the internal reset length
	sequence s_pin_driven;
		$rose(reset_pin_oe);
	endsequence
	sequence s_pin_freed;
		##[1:24] !reset_pin_oe;
	endsequence

	// internal reset: pin, length and record
	a_trap_drives_pin: assert property (@(posedge clk) disable iff (!rst_b)
		s_trap_reset |=> reset_pin_oe && core_reset)
		else $error("trap reset did not drive pin");
	a_trap_status: assert property (@(posedge clk) disable iff (!rst_b)
		s_trap_reset |=> status_ff[ST_TRAP_RST])
		else $error("trap reset not recorded");
	a_int_rst_bound: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff == INT_RST && clk_en) |-> int_cnt_ff < 5'(RST_LEN))
		else $error("internal reset too long");
	a_int_pin_held: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff == INT_RST) |-> reset_pin_oe && core_reset)
		else $error("pin released during internal reset");
	a_pin_open_drain: assert property (@(posedge clk) disable iff (!rst_b)
		reset_pin_oe |-> !reset_pin_out)
		else $error("pin driven high");
	a_clk_rst_ends: assert property (@(posedge clk) disable iff (!rst_b || !clk_en)
		s_pin_driven |-> s_pin_freed)
		else $error("pin not released in time");

	// system clock reset: start, record and a live oscillator
	a_clk_rst_start: assert property (@(posedge clk) disable iff (!rst_b)
		s_clk_bad |=> state_ff == INT_RST)
		else $error("clock reset not raised");
	a_clk_status: assert property (@(posedge clk) disable iff (!rst_b)
		s_clk_bad |=> status_ff[ST_CLK_RST])
		else $error("clock reset not recorded");
	a_osc_kept: assert property (@(posedge clk) disable iff (!rst_b)
		s_clk_bad |=> osc_run &&
			(ctrl_ff[CTRL_CLK_SEL] ? ctrl_ff[CTRL_SUB_OSC] : ctrl_ff[CTRL_MAIN_OSC]))
		else $error("selected oscillator disabled");

	// external reset: minimum low time, hold and release to the vector
	a_ext_min: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff == RUN && nxt_state == EXT_RST) |-> low_cnt_ff == 5'(EXT_MIN_CYC - 1))
		else $error("external reset count wrong");
	a_ext_status: assert property (@(posedge clk) disable iff (!rst_b)
		s_ext_hit |=> status_ff[ST_EXT_RST] && core_reset)
		else $error("external reset not applied");
	a_ext_held: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff == EXT_RST) |-> core_reset)
		else $error("core ran during external reset");
	a_release_vec: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff == EXT_RST && reset_pin_in && clk_en) |=>
			!core_reset && start_vector == VEC_ADDR)
		else $error("release not to vector");

	// traps, latches and the interrupt output
	a_ram_trap_gate: assert property (@(posedge clk) disable iff (!rst_b)
		(fetch_valid && fetch_in_ram && !fetch_in_sfr && !ctrl_ff[CTRL_RAM_TRAP]) |->
			!trap_hit)
		else $error("ram trap while disabled");
	a_sfr_trap: assert property (@(posedge clk) disable iff (!rst_b)
		(fetch_valid && fetch_in_sfr && state_ff == RUN) |-> trap_hit)
		else $error("sfr fetch not trapped");
	a_trap_irq_path: assert property (@(posedge clk) disable iff (!rst_b)
		(trap_irq && clk_en) |=> latch_ff[LATCH_TRAP] && !core_reset)
		else $error("trap interrupt not latched");
	a_latch_clear: assert property (@(posedge clk) disable iff (!rst_b)
		(any_rst && clk_en) |=> latch_ff == 16'h0000)
		else $error("latches survived reset");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
		(clk_en && |(status_ff & mask_ff) && !rd_status) |=> irq)
		else $error("interrupt output not raised");
	a_trap_default: assert property (@(posedge clk) disable iff (!rst_b)
		(state_ff != RUN) |-> ctrl_ff[CTRL_TRAP_ACT] || $past(state_ff) == RUN)
		else $error("trap action not default");
endmodule

/* File: src/reset_source_pkg.sv */
// package: constants for the reset source logic
package reset_source_pkg;
	// bus register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_LATCH  = 8'h0C;
	// control register fields
	localparam int CTRL_RAM_TRAP   = 0;
	localparam int CTRL_TRAP_ACT   = 1;
	localparam int CTRL_MAIN_OSC   = 2;
	localparam int CTRL_SUB_OSC    = 3;
	localparam int CTRL_CLK_SEL    = 4;
	localparam logic [4:0] CTRL_RESET = 5'h0E;
	// status and mask fields
	localparam int ST_EXT_RST   = 0;
	localparam int ST_TRAP_RST  = 1;
	localparam int ST_TRAP_IRQ  = 2;
	localparam int ST_CLK_RST   = 3;
	localparam int ST_W         = 4;
	// interrupt latch position of the trap interrupt
	localparam int LATCH_TRAP   = 2;
	localparam int LATCH_W      = 16;
	// timing: oscillator periods per machine cycle and limits
	localparam int OSC_PER_MC     = 4;
	localparam int EXT_MIN_MC     = 3;
	localparam int EXT_MIN_CYC    = EXT_MIN_MC * OSC_PER_MC;
	localparam int INT_RST_MAX    = 24;
	// reset vector location
	localparam logic [15:0] VEC_ADDR = 16'hFFFE;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: test/reset_pin_model.sv */
// external reset supervisor model: open-drain reset pin with pull-up
`timescale 1ns/1ps
module reset_pin_model (
	// supervisor request and device drive
	input  wire logic hold_low,
	input  wire logic dev_oe,
	input  wire logic dev_out,
	// resolved pin level
	output logic      pin_level
);
	// pull-up wins unless a party pulls low; the bench sets how long it is held
	assign pin_level = (hold_low || (dev_oe && !dev_out)) ? 1'b0 : 1'b1;
endmodule

/* File: test/reset_source_logic_bench.sv */
// bench for the reset source logic
`timescale 1ns/1ps
module reset_source_logic_bench;
	import reset_source_pkg::*;
	localparam int RLEN = INT_RST_MAX;
	logic        clk, rst_b, clk_en, hold_low, pin_level, pin_out, pin_oe, bad;
	logic        fetch_valid, fetch_in_sfr, fetch_in_ram, core_reset, osc_run, irq, cnt_clr;
	logic [15:0] irq_set, start_vector;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, rd_d;
	logic [3:0]  s_wstrb;
	logic [1:0]  s_bresp, s_rresp, resp;
	logic        s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready;
	int          err_total, checks, oe_cyc, rst_cyc, osc_off;
	// pre and new oscillator control values
	logic [15:0] clk_tab [5] = '{16'h0E02, 16'h0E0A, 16'h1E16, 16'h1E1A, 16'h0E06};

	reset_pin_model i_pin (.hold_low(hold_low), .dev_oe(pin_oe), .dev_out(pin_out),
		.pin_level(pin_level));
	reset_source_logic #(.RST_LEN(RLEN)) i_dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
		.reset_pin_in(pin_level), .reset_pin_out(pin_out), .reset_pin_oe(pin_oe),
		.fetch_valid(fetch_valid), .fetch_in_sfr(fetch_in_sfr), .fetch_in_ram(fetch_in_ram),
		.irq_set(irq_set), .core_reset(core_reset), .start_vector(start_vector),
		.osc_run(osc_run), .irq(irq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
		.s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
		.s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

	always #20 clk = ~clk;
	// cycle counts since the last clear; a request line keeps the clear race free
	always @(posedge clk) begin
		oe_cyc  <= cnt_clr ? 0 : oe_cyc + int'(pin_oe);
		rst_cyc <= cnt_clr ? 0 : rst_cyc + int'(core_reset);
		osc_off <= cnt_clr ? 0 : osc_off + int'(!osc_run);
	end

	// a disable write is illegal if it leaves the selected clock without a source
	function automatic logic illegal(input logic [7:0] p, input logic [7:0] n);
		return (p[CTRL_MAIN_OSC] && !n[CTRL_MAIN_OSC] && (!n[CTRL_SUB_OSC] || !p[CTRL_CLK_SEL]))
			|| (p[CTRL_SUB_OSC] && !n[CTRL_SUB_OSC] && p[CTRL_CLK_SEL]);
	endfunction
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// bounded wait step; running out is a mismatch
	task automatic guard(inout int n);
		n++;
		if (n > 200) begin
			err_total++;
			close_out();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		int   n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge clk);
		s_awaddr <= a;
		s_wdata <= d;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
			if (aw && s_awready === 1'b1) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready === 1'b1) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
		end while (s_bvalid !== 1'b1);
		resp = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic ar;
		int   n;
		ar = 1'b1;
		n = 0;
		@(posedge clk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clk);
			guard(n);
			if (ar && s_arready === 1'b1) begin
				ar = 1'b0;
				s_arvalid <= 1'b0;
			end
		end while (s_rvalid !== 1'b1);
		rd_d = s_rdata;
		resp = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(nm, rd_d, e);
	endtask
	task automatic fetch(input logic sfr, input logic ram);
		@(posedge clk);
		fetch_valid <= 1'b1;
		fetch_in_sfr <= sfr;
		fetch_in_ram <= ram;
		@(posedge clk);
		fetch_valid <= 1'b0;
		repeat (RLEN + 8) @(posedge clk);
	endtask
	task automatic pulse_irq(input logic [15:0] v);
		@(posedge clk);
		irq_set <= v;
		@(posedge clk);
		irq_set <= 16'h0000;
	endtask
	task automatic hold(input int n);
		@(posedge clk);
		hold_low <= 1'b1;
		repeat (n) @(posedge clk);
		hold_low <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic clr();
		@(posedge clk);
		cnt_clr <= 1'b1;
		@(posedge clk);
		cnt_clr <= 1'b0;
	endtask
	task automatic wait_run();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			guard(n);
		end while (core_reset !== 1'b0);
	endtask

	// main sequence
	initial begin
		{clk, rst_b, hold_low, fetch_valid, fetch_in_sfr, fetch_in_ram, cnt_clr} = '0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, irq_set} = '0;
		{s_awaddr, s_araddr, s_wdata} = '0;
		s_wstrb = 4'hF;
		clk_en = 1'b1;
		{err_total, checks} = '0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wait_run();
		chk("vector", start_vector, VEC_ADDR);
		chk("osc", osc_run, 1'b1);
		rdc("ctrl", OFS_CTRL, 8'h0E);
		rdc("latch", OFS_LATCH, 8'h00);
		rd(OFS_STATUS);
		wr(8'h10, 32'h0000_0000);
		chk("wresp", resp, RESP_SLVERR);
		rd(8'h10);
		chk("rresp", resp, RESP_SLVERR);
		// pin low one sample short of the limit, then exactly at it
		clr();
		hold(EXT_MIN_CYC - 1);
		chk("short", rst_cyc, 0);
		clr();
		hold(EXT_MIN_CYC);
		wait_run();
		chk("long", rst_cyc > 0, 1'b1);
		rdc("st", OFS_STATUS, 8'h01);
		// sfr fetch with default action resets and drives the pin
		pulse_irq(16'h0100);
		rdc("latch", OFS_LATCH, 16'h0100);
		clr();
		fetch(1'b1, 1'b0);
		chk("trap oe", oe_cyc, RLEN);
		wait_run();
		rdc("st", OFS_STATUS, 8'h02);
		rdc("latch", OFS_LATCH, 8'h00);
		// ram area excluded, then included with interrupt action
		wr(OFS_CTRL, 8'h0C);
		clr();
		fetch(1'b0, 1'b1);
		rdc("st", OFS_STATUS, 8'h00);
		wr(OFS_CTRL, 8'h0D);
		fetch(1'b0, 1'b1);
		chk("irq masked", irq, 1'b0);
		rdc("latch", OFS_LATCH, 8'h04);
		wr(OFS_MASK, 8'h04);
		repeat (2) @(posedge clk);
		chk("irq", irq, 1'b1);
		rdc("st", OFS_STATUS, 8'h04);
		repeat (2) @(posedge clk);
		chk("irq clear", irq, 1'b0);
		chk("irq oe", oe_cyc, 0);
		// clock enable low: a set request must not land in the latches
		@(posedge clk);
		clk_en <= 1'b0;
		pulse_irq(16'h0200);
		@(posedge clk);
		clk_en <= 1'b1;
		rdc("frozen", OFS_LATCH, 16'h0004);
		// oscillator disable writes, legal and illegal
		for (int i = 0; i < 5; i++) begin
			wr(OFS_CTRL, clk_tab[i][15:8]);
			pulse_irq(16'h8000);
			clr();
			wr(OFS_CTRL, clk_tab[i][7:0]);
			repeat (RLEN + 8) @(posedge clk);
			bad = illegal(clk_tab[i][15:8], clk_tab[i][7:0]);
			chk("clk oe", oe_cyc, bad ? RLEN : 0);
			chk("osc off", osc_off, 0);
			rdc("ctrl", OFS_CTRL, bad ? 8'h0E : clk_tab[i][7:0]);
			rdc("st", OFS_STATUS, bad ? 8'h08 : 8'h00);
			rdc("latch", OFS_LATCH, bad ? 16'h0000 : 16'h8000);
		end
		close_out();
	end
endmodule
